// >>> verification/irc_partner.sv
`timescale 1ns/10ps
// ****************************************************************
// IR receiver module model: output low while a burst is seen.
// ****************************************************************
module irc_partner #(parameter int TICK_C = 500) (
    input  wire logic clk_sys_i,
    output logic      ir_rx_n_o
);
    // The module's pull-up holds the output high between bursts.
    initial ir_rx_n_o = 1'b1;

    // Holds a level for a span in microseconds; moves just after an edge.
    task automatic hold(input logic lvl, input int us);
        ir_rx_n_o = lvl;
        repeat (us / 10 * TICK_C) @(posedge clk_sys_i);
        #1;
    endtask

    // 32-bit frame: long burst, gap, bits LSB first by gap length, closing burst.
    task automatic long_frame(input logic [31:0] w);
        hold(1'b0, 9000);
        hold(1'b1, 4500);
        for (int i = 0; i < 32; i++) begin
            hold(1'b0, 560);
            hold(1'b1, w[i] ? 1690 : 560);
        end
        hold(1'b0, 560);
        hold(1'b1, 20000);
    endtask

    // Held-key code sent by a 32-bit remote.
    task automatic repeat_code();
        hold(1'b0, 9000);
        hold(1'b1, 2250);
        hold(1'b0, 560);
        hold(1'b1, 20000);
    endtask

    // 12-bit frame: header burst, then gap and burst per bit, burst length codes the bit.
    task automatic short_frame(input logic [11:0] b);
        hold(1'b0, 2400);
        for (int i = 0; i < 12; i++) begin
            hold(1'b1, 600);
            hold(1'b0, b[i] ? 1200 : 600);
        end
        hold(1'b1, 20000);
    endtask
endmodule // irc_partner

// >>> verification/irc_top_assertions.sv
`timescale 1ns/10ps
// ****************************************************************
// Port-level checker for the remote codec top.
// ****************************************************************
module irc_top_assertions
    import irc_pkg::*;
#(
    parameter int UNIT_C  = UNIT_CYC,
    parameter int FRAME_C = FRAME_CYC
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        transmit_remote_frame_i,
    input wire irc_tx_req_t tx_req_data_i,
    input wire logic        tx_busy_o,
    input wire logic        ir_led_o,
    input wire logic        ir_rx_n_i,
    input wire logic        rx_start_i,
    input wire logic        stop_remote_decoder_i,
    input wire irc_frame_t  rx_frame_o,
    input wire logic        rx_event_o,
    input wire logic        rx_enabled_o
);
    localparam int HI_MAX = CARRIER_HALF;
    int hi_cnt;
    int next_hi_cnt;
    int busy_cnt;
    int next_busy_cnt;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Run lengths of a lit LED and of busy; a stuck carrier or busy overruns them.
    always_comb begin
        next_hi_cnt   = ir_led_o ? hi_cnt + 1 : 0;
        next_busy_cnt = tx_busy_o ? busy_cnt + 1 : 0;
    end

    // Counters clear in reset so the first checks after release start clean.
    always_ff @(posedge clk_sys_i) begin
        hi_cnt   <= rst_n_i ? next_hi_cnt : 0;
        busy_cnt <= rst_n_i ? next_busy_cnt : 0;
    end

    a_busy_on_req: assert property (transmit_remote_frame_i && !tx_busy_o |=> tx_busy_o && ir_led_o)
        else $error("busy or LED missing after an accepted send");
    a_busy_holds: assert property ($rose(tx_busy_o) |-> tx_busy_o [*8])
        else $error("busy dropped right after it rose");
    a_busy_bound: assert property (busy_cnt <= FRAME_C + 1)
        else $error("busy lasted longer than one frame time");
    a_carrier_half: assert property (hi_cnt <= HI_MAX)
        else $error("LED stayed lit longer than a carrier half period");
    a_led_idle_low: assert property (!tx_busy_o |-> !ir_led_o)
        else $error("LED lit while the transmitter is idle");
    a_event_single: assert property (rx_event_o |=> !rx_event_o)
        else $error("receive event longer than one cycle");
    a_frame_moves_event: assert property ($changed(rx_frame_o) |-> rx_event_o)
        else $error("decoded frame changed without an event");
    a_stop_halts: assert property (stop_remote_decoder_i |=> !rx_enabled_o)
        else $error("decoder still running after stop");
    a_start_runs: assert property (rx_start_i && !stop_remote_decoder_i |=> rx_enabled_o)
        else $error("decoder not running after start");
    a_no_event_off: assert property (!rx_enabled_o && !$past(rx_enabled_o) &&
        !$past(rx_enabled_o, 2) |-> !rx_event_o)
        else $error("event raised while the decoder is stopped");

    c_tx_sent: cover property (transmit_remote_frame_i && !tx_busy_o);
    c_rx_repeat: cover property (rx_event_o && rx_frame_o.repeat_key);
    c_rx_short: cover property (rx_event_o && !rx_frame_o.proto_long);
endmodule // irc_top_assertions

bind irc_top irc_top_assertions #(.UNIT_C(UNIT_C), .FRAME_C(FRAME_C)) irc_top_assertions_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .transmit_remote_frame_i(transmit_remote_frame_i),
    .tx_req_data_i(tx_req_data_i), .tx_busy_o(tx_busy_o), .ir_led_o(ir_led_o),
    .ir_rx_n_i(ir_rx_n_i), .rx_start_i(rx_start_i), .stop_remote_decoder_i(stop_remote_decoder_i),
    .rx_frame_o(rx_frame_o), .rx_event_o(rx_event_o), .rx_enabled_o(rx_enabled_o));

// >>> verification/irc_top_tb_top.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench of the remote codec.
// ****************************************************************
module irc_top_tb_top;
    import irc_pkg::*;
    localparam int U = 700;
    localparam int F = 29000;
    localparam int T = 1;
    logic        clk_sys = 1'b0;
    logic        rst_n;
    logic        tx_req;
    irc_tx_req_t tx_data;
    logic        tx_busy;
    logic        ir_led;
    logic        ir_rx_n;
    logic        rx_start;
    logic        rx_stop;
    irc_frame_t  rx_frame;
    logic        rx_event;
    logic        rx_enabled;
    irc_frame_t  last_frame;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          ev_count = 0;

    // A unit long enough that the carrier toggles inside marks.
    always #10 clk_sys = ~clk_sys;

    irc_top #(.UNIT_C(U), .FRAME_C(F), .TICK_C(T)) irc_top_i (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .transmit_remote_frame_i(tx_req),
        .tx_req_data_i(tx_data), .tx_busy_o(tx_busy), .ir_led_o(ir_led), .ir_rx_n_i(ir_rx_n),
        .rx_start_i(rx_start), .stop_remote_decoder_i(rx_stop), .rx_frame_o(rx_frame),
        .rx_event_o(rx_event), .rx_enabled_o(rx_enabled));

    irc_partner #(.TICK_C(T)) irc_partner_i (.clk_sys_i(clk_sys), .ir_rx_n_o(ir_rx_n));

    // Events last one cycle, so they are counted and their frame kept here.
    always @(posedge clk_sys) begin
        if (rx_event === 1'b1) begin
            ev_count++;
            last_frame = rx_frame;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Expected LED level t cycles after the accepting edge.
    function automatic logic exp_led(input int t, input logic [11:0] b);
        int s;
        int n;
        s = 1 + HDR_UNITS * U;
        if (t < 1) return 1'b0;
        if (t < s) return ((t - 1) / CARRIER_HALF) % 2 == 0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            if (t < s + SPACE_UNITS * U) return 1'b0;
            s += SPACE_UNITS * U;
            n = b[i] ? ONE_UNITS * U : ZERO_UNITS * U;
            if (t < s + n) return ((t - s) / CARRIER_HALF) % 2 == 0;
            s += n;
        end
        return 1'b0;
    endfunction

    // Whole frame compared cycle by cycle; a second request mid-frame must be ignored.
    task automatic tx_frame(input irc_tx_req_t r);
        tx_data = r;
        tx_req = 1'b1;
        @(posedge clk_sys);
        #1;
        tx_req = 1'b0;
        for (int t = 1; t <= F + 2; t++) begin
            if (t == 5) begin
                tx_req = 1'b1;
                tx_data = ~r;
            end
            if (t == 6) tx_req = 1'b0;
            if (t <= F) chk(tx_busy, 1'b1);
            if (t == F + 2) chk(tx_busy, 1'b0);
            chk(ir_led, exp_led(t, r));
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic rx_expect(input int n0, input irc_frame_t f);
        chk(ev_count - n0, 1);
        chk(last_frame, f);
    endtask

    // 32-bit frame then held-key code; bytes come out mirrored.
    task automatic rx_long();
        int n0;
        rx_start = 1'b1;
        @(posedge clk_sys);
        #1;
        rx_start = 1'b0;
        chk(rx_enabled, 1'b1);
        n0 = ev_count;
        irc_partner_i.long_frame({~8'h34, 8'h34, ~8'h12, 8'h12});
        rx_expect(n0, {8'h48, 8'h2c, 1'b1, 1'b0});
        n0 = ev_count;
        irc_partner_i.repeat_code();
        rx_expect(n0, {8'h48, 8'h2c, 1'b1, 1'b1});
    endtask

    task automatic rx_short();
        int n0;
        n0 = ev_count;
        irc_partner_i.short_frame({5'h0b, 7'h5a});
        rx_expect(n0, {8'h0b, 8'h5a, 1'b0, 1'b0});
        n0 = ev_count;
        irc_partner_i.short_frame({5'h0b, 7'h5a});
        rx_expect(n0, {8'h0b, 8'h5a, 1'b0, 1'b1});
    endtask

    // After stop a good frame must leave outputs and events untouched.
    task automatic rx_halt();
        int n0;
        irc_frame_t f;
        rx_stop = 1'b1;
        @(posedge clk_sys);
        #1;
        rx_stop = 1'b0;
        chk(rx_enabled, 1'b0);
        n0 = ev_count;
        f = rx_frame;
        irc_partner_i.short_frame({5'h15, 7'h2a});
        chk(ev_count - n0, 0);
        chk(rx_frame, f);
    endtask

    // Main sequence: reset, two boundary sends back to back, then receive.
    initial begin
        rst_n = 1'b0;
        tx_req = 1'b0;
        tx_data = '0;
        rx_start = 1'b0;
        rx_stop = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        chk(ir_led, 1'b0);
        tx_frame({5'h1f, 7'h00});
        tx_frame({5'h00, 7'h7f});
        rx_long();
        rx_short();
        rx_halt();
        results();
    end

    // Cuts a hang short past the expected run of about 82,000 cycles.
    initial begin
        repeat (100_000) @(posedge clk_sys);
        bad_count++;
        results();
    end
endmodule // irc_top_tb_top

// >>> verilog/irc_pkg.sv
// ****************************************************************
// Timing and field constants shared by the remote codec.
// ****************************************************************
package irc_pkg;

    // System clock rate and derived microsecond scale.
    localparam int CLK_HZ         = 50_000_000;
    localparam int CYC_PER_US     = CLK_HZ / 1_000_000;

    // Transmit carrier, about 38 kHz, toggled every half period.
    localparam int CARRIER_HZ     = 38_000;
    localparam int CARRIER_HALF   = CLK_HZ / (2 * CARRIER_HZ);

    // Transmit timing: one unit of 600 us, frame busy time of 25 ms.
    localparam int UNIT_US        = 600;
    localparam int UNIT_CYC       = UNIT_US * CYC_PER_US;
    localparam int FRAME_MS       = 25;
    localparam int FRAME_CYC      = FRAME_MS * 1000 * CYC_PER_US;
    localparam int HDR_UNITS      = 4;
    localparam int SPACE_UNITS    = 1;
    localparam int ONE_UNITS      = 2;
    localparam int ZERO_UNITS     = 1;

    // Transmit frame layout.
    localparam int CMD_BITS       = 7;
    localparam int ADDR_BITS      = 5;
    localparam int FRAME_BITS     = CMD_BITS + ADDR_BITS;
    localparam int CNT_W          = 24;

    // Receive measurement tick of 10 us.
    localparam int TICK_US        = 10;
    localparam int TICK_CYC       = TICK_US * CYC_PER_US;
    localparam int DUR_W          = 12;
    localparam int LONG_BITS      = 32;

    // Receive windows in microseconds.
    localparam int L_HDR_MIN_US   = 8000;
    localparam int L_HDR_MAX_US   = 10000;
    localparam int L_GO_MIN_US    = 4000;
    localparam int L_GO_MAX_US    = 5000;
    localparam int L_RPT_MIN_US   = 2000;
    localparam int L_RPT_MAX_US   = 2500;
    localparam int L_ONE_MIN_US   = 1120;
    localparam int S_HDR_MIN_US   = 2000;
    localparam int S_HDR_MAX_US   = 2800;
    localparam int S_ONE_MIN_US   = 900;
    localparam int TIMEOUT_US     = 15000;
    localparam int HOLD_US        = 30000;

    // Same windows as counts of receive ticks.
    localparam logic [DUR_W-1:0] L_HDR_MIN = DUR_W'(L_HDR_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] L_HDR_MAX = DUR_W'(L_HDR_MAX_US / TICK_US);
    localparam logic [DUR_W-1:0] L_GO_MIN  = DUR_W'(L_GO_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] L_GO_MAX  = DUR_W'(L_GO_MAX_US / TICK_US);
    localparam logic [DUR_W-1:0] L_RPT_MIN = DUR_W'(L_RPT_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] L_RPT_MAX = DUR_W'(L_RPT_MAX_US / TICK_US);
    localparam logic [DUR_W-1:0] L_ONE_MIN = DUR_W'(L_ONE_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] S_HDR_MIN = DUR_W'(S_HDR_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] S_HDR_MAX = DUR_W'(S_HDR_MAX_US / TICK_US);
    localparam logic [DUR_W-1:0] S_ONE_MIN = DUR_W'(S_ONE_MIN_US / TICK_US);
    localparam logic [DUR_W-1:0] TIMEOUT   = DUR_W'(TIMEOUT_US / TICK_US);
    localparam logic [DUR_W-1:0] HOLD      = DUR_W'(HOLD_US / TICK_US);
    localparam logic [DUR_W-1:0] DUR_MAX   = 12'hfff;

    // Send request: address and key command.
    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [CMD_BITS-1:0]  cmd;
    } irc_tx_req_t;

    // Decoded frame presented by the receiver.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] cmd;
        logic       proto_long;
        logic       repeat_key;
    } irc_frame_t;

endpackage

// >>> verilog/irc_top.sv
`timescale 1ns/10ps
// Contract
// [R1] One 12-bit frame sent per send request.
// [R2] Requester gives address zero to thirty-one.
// [R3] Requester gives command zero to one twenty-seven.
// [R4] Marks are modulated with a 38 kHz carrier.
// [R5] Output idles low; high lights the LED.
// [R6] Busy asserted for the whole 25 ms send.
// [R7] Long protocol bytes shown bit-reversed.
// [R8] Stop halts decoding and output updates.
// [R9] Decode both long and 12-bit protocols.
// [R10] Address and command update per valid frame.
// [R11] Event on new key and each repeat.
// [R12] Header 2.4 ms; bits command first, LSB first.
// [R13] Carrier only in marks; low after last bit.
// ****************************************************************
// Remote codec top: transmitter instance and receive decoder.
// ****************************************************************
module irc_top
    import irc_pkg::*;
#(
    parameter int UNIT_C  = UNIT_CYC,
    parameter int FRAME_C = FRAME_CYC,
    parameter int TICK_C  = TICK_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        transmit_remote_frame_i,
    input  wire irc_tx_req_t tx_req_data_i,
    output logic             tx_busy_o,
    output logic             ir_led_o,
    input  wire logic        ir_rx_n_i,
    input  wire logic        rx_start_i,
    input  wire logic        stop_remote_decoder_i,
    output irc_frame_t       rx_frame_o,
    output logic             rx_event_o,
    output logic             rx_enabled_o
);
    typedef enum logic [1:0] {R_IDLE, R_LSTART, R_LDATA, R_SDATA} irc_rx_state_t;

    localparam logic [8:0] TICK_LAST = 9'(TICK_C - 1);
    localparam logic [5:0] L_LAST    = 6'(LONG_BITS - 1);
    localparam logic [5:0] S_LAST    = 6'(FRAME_BITS - 1);

    // ****************************************************************
    // Transmitter
    // ****************************************************************

    // The requester keeps address and command within their fields; the struct enforces widths.
    irc_tx #(
        .UNIT_C  (UNIT_C),
        .FRAME_C (FRAME_C)
    ) u_tx (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .req_i      (transmit_remote_frame_i), // [R2] [R3]
        .req_data_i (tx_req_data_i),
        .busy_o     (tx_busy_o),
        .led_o      (ir_led_o)
    );

    // ****************************************************************
    // Input synchroniser, tick divider and duration counter
    // ****************************************************************

    logic                ir_s1, ir_s2, ir_prev;
    logic [8:0]          tick_cnt, next_tick_cnt;
    logic                tick, next_tick;
    logic [DUR_W-1:0]    dur, next_dur;
    logic                edge_seen;
    logic                mark_ended;

    // The receiver module pulls its output low during a burst, so low is a mark.
    assign edge_seen  = (ir_s2 != ir_prev);
    assign mark_ended = edge_seen && !ir_prev;

    // Tick every 10 us; durations saturate so a long idle never wraps into a window.
    always_comb begin
        next_tick     = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
        if (edge_seen) begin
            next_dur = '0;
        end else if (tick && (dur != DUR_MAX)) begin
            next_dur = dur + 1'b1;
        end else begin
            next_dur = dur;
        end
    end

    // Synchroniser and measurement registers; the input idles high.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ir_s1    <= 1'b1;
            ir_s2    <= 1'b1;
            ir_prev  <= 1'b1;
            tick_cnt <= '0;
            tick     <= 1'b0;
            dur      <= '0;
        end else begin
            ir_s1    <= ir_rx_n_i;
            ir_s2    <= ir_s1;
            ir_prev  <= ir_s2;
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
            dur      <= next_dur;
        end
    end

    // ****************************************************************
    // Decoder state machine
    // ****************************************************************

    irc_rx_state_t         state, next_state;
    logic [5:0]            nbits, next_nbits;
    logic [LONG_BITS-1:0]  sr32, next_sr32;
    logic [FRAME_BITS-1:0] sr12, next_sr12;
    irc_frame_t            next_frame;
    logic                  next_event;
    logic                  next_enabled;
    logic                  have_long, next_have_long;
    logic                  held, next_held;

    // Edges are classified by the length of the level that just ended.
    always_comb begin
        next_state     = state;
        next_nbits     = nbits;
        next_sr32      = sr32;
        next_sr12      = sr12;
        next_frame     = rx_frame_o;
        next_event     = 1'b0;
        next_have_long = have_long;
        next_held      = held;
        next_enabled   = rx_enabled_o;
        if (rx_start_i) begin
            next_enabled = 1'b1;
        end
        if (stop_remote_decoder_i) begin
            next_enabled = 1'b0; // [R8]
        end
        if (!rx_enabled_o) begin
            next_state     = R_IDLE; // [R8]
            next_have_long = 1'b0;
            next_held      = 1'b0;
        end else if ((state != R_IDLE) && (dur >= TIMEOUT)) begin
            next_state = R_IDLE;
        end else begin
            unique case (state)
                R_IDLE: begin
                    if (dur >= HOLD) begin
                        next_held = 1'b0;
                    end
                    if (mark_ended && (dur >= L_HDR_MIN) && (dur <= L_HDR_MAX)) begin // [R9]
                        next_state = R_LSTART;
                    end else if (mark_ended && (dur >= S_HDR_MIN) && (dur <= S_HDR_MAX)) begin
                        next_state = R_SDATA; // [R9]
                        next_nbits = '0;
                    end
                end
                R_LSTART: begin
                    if (edge_seen && !mark_ended) begin
                        next_state = R_IDLE;
                        next_nbits = '0;
                        if ((dur >= L_GO_MIN) && (dur <= L_GO_MAX)) begin
                            next_state = R_LDATA;
                        end else if ((dur >= L_RPT_MIN) && (dur <= L_RPT_MAX) && have_long) begin
                            next_frame.repeat_key = 1'b1; // [R11]
                            next_event            = 1'b1; // [R11]
                        end
                    end else if (mark_ended) begin
                        next_state = R_IDLE;
                    end
                end
                R_LDATA: begin
                    if (edge_seen && !mark_ended) begin
                        // Shifting in at the bottom puts received bit 0 at the top of each byte.
                        next_sr32  = {sr32[LONG_BITS-2:0], (dur >= L_ONE_MIN)}; // [R7]
                        next_nbits = nbits + 1'b1;
                        if (nbits == L_LAST) begin
                            next_state = R_IDLE;
                            // Address check is skipped so extended eight-bit addresses pass.
                            if (next_sr32[15:8] == ~next_sr32[7:0]) begin
                                next_frame.addr       = next_sr32[31:24]; // [R7] [R10]
                                next_frame.cmd        = next_sr32[15:8]; // [R7] [R10]
                                next_frame.proto_long = 1'b1;
                                next_frame.repeat_key = 1'b0;
                                next_event            = 1'b1; // [R11]
                                next_have_long        = 1'b1;
                            end
                        end
                    end
                end
                R_SDATA: begin
                    if (mark_ended) begin
                        next_sr12  = {(dur >= S_ONE_MIN), sr12[FRAME_BITS-1:1]};
                        next_nbits = nbits + 1'b1;
                        if (nbits == S_LAST) begin
                            next_state            = R_IDLE;
                            next_frame.addr       = {3'h0, next_sr12[FRAME_BITS-1:CMD_BITS]}; // [R10]
                            next_frame.cmd        = {1'h0, next_sr12[CMD_BITS-1:0]}; // [R10]
                            next_frame.proto_long = 1'b0;
                            // A held key resends the same frame; flag it as a repeat.
                            next_frame.repeat_key = held && !rx_frame_o.proto_long &&
                                                    (next_frame.addr == rx_frame_o.addr) &&
                                                    (next_frame.cmd == rx_frame_o.cmd); // [R11]
                            next_event            = 1'b1; // [R11]
                            next_held             = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Decoder registers; outputs freeze while the decoder is stopped.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state        <= R_IDLE;
            nbits        <= '0;
            sr32         <= '0;
            sr12         <= '0;
            rx_frame_o   <= '0;
            rx_event_o   <= 1'b0;
            rx_enabled_o <= 1'b0;
            have_long    <= 1'b0;
            held         <= 1'b0;
        end else begin
            state        <= next_state;
            nbits        <= next_nbits;
            sr32         <= next_sr32;
            sr12         <= next_sr12;
            rx_frame_o   <= next_frame;
            rx_event_o   <= next_event;
            rx_enabled_o <= next_enabled;
            have_long    <= next_have_long;
            held         <= next_held;
        end
    end

endmodule // irc_top

// >>> verilog/irc_tx.sv
`timescale 1ns/10ps
// ****************************************************************
// Transmitter of the 12-bit pulse-width remote frame.
// ****************************************************************
module irc_tx
    import irc_pkg::*;
#(
    parameter int UNIT_C  = UNIT_CYC,
    parameter int FRAME_C = FRAME_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_i,
    input  wire irc_tx_req_t req_data_i,
    output logic             busy_o,
    output logic             led_o
);
    typedef enum logic [2:0] {T_IDLE, T_HDR, T_SPACE, T_MARK, T_PAD} irc_tx_state_t;

    localparam logic [CNT_W-1:0] HDR_LEN   = CNT_W'(HDR_UNITS * UNIT_C - 1);
    localparam logic [CNT_W-1:0] SPACE_LEN = CNT_W'(SPACE_UNITS * UNIT_C - 1);
    localparam logic [CNT_W-1:0] ONE_LEN   = CNT_W'(ONE_UNITS * UNIT_C - 1);
    localparam logic [CNT_W-1:0] ZERO_LEN  = CNT_W'(ZERO_UNITS * UNIT_C - 1);
    localparam logic [CNT_W-1:0] FRAME_END = CNT_W'(FRAME_C - 1);
    localparam logic [9:0]       CAR_LAST  = 10'(CARRIER_HALF - 1);
    localparam logic [3:0]       LAST_BIT  = 4'(FRAME_BITS - 1);

    irc_tx_state_t         state, next_state;
    logic [CNT_W-1:0]      seg, next_seg;
    logic [CNT_W-1:0]      frame_cnt, next_frame_cnt;
    logic [3:0]            bit_idx, next_bit_idx;
    logic [FRAME_BITS-1:0] sr, next_sr;
    logic [9:0]            car_cnt, next_car_cnt;
    logic                  car_ph, next_car_ph;
    logic                  next_led, next_busy;

    // Sequencer: header burst, then space and mark per bit, then pad to the frame time.
    always_comb begin
        next_state     = state;
        next_seg       = (seg != '0) ? seg - 1'b1 : seg;
        next_frame_cnt = (state != T_IDLE) ? frame_cnt + 1'b1 : frame_cnt;
        next_bit_idx   = bit_idx;
        next_sr        = sr;
        next_busy      = busy_o;
        if (car_cnt == CAR_LAST) begin // [R4]
            next_car_cnt = '0;
            next_car_ph  = ~car_ph;
        end else begin
            next_car_cnt = car_cnt + 1'b1;
            next_car_ph  = car_ph;
        end
        unique case (state)
            T_IDLE: begin
                if (req_i) begin // [R1]
                    next_state     = T_HDR; // [R12]
                    next_seg       = HDR_LEN;
                    next_sr        = {req_data_i.addr, req_data_i.cmd}; // [R12]
                    next_bit_idx   = '0;
                    next_frame_cnt = '0;
                    next_busy      = 1'b1; // [R6]
                    next_car_cnt   = '0;
                    next_car_ph    = 1'b1;
                end
            end
            T_HDR: begin
                if (seg == '0) begin
                    next_state = T_SPACE;
                    next_seg   = SPACE_LEN;
                end
            end
            T_SPACE: begin
                if (seg == '0) begin
                    next_state   = T_MARK;
                    next_seg     = sr[0] ? ONE_LEN : ZERO_LEN; // [R12]
                    next_car_cnt = '0;
                    next_car_ph  = 1'b1;
                end
            end
            T_MARK: begin
                if (seg == '0) begin
                    next_sr      = sr >> 1; // [R12]
                    next_bit_idx = bit_idx + 1'b1;
                    next_seg     = SPACE_LEN;
                    next_state   = (bit_idx == LAST_BIT) ? T_PAD : T_SPACE; // [R13]
                end
            end
            T_PAD: begin
                if (frame_cnt >= FRAME_END) begin // [R6]
                    next_state = T_IDLE;
                    next_busy  = 1'b0;
                end
            end
        endcase
        // Carrier reaches the pin only in marks, so the pin rests low otherwise.
        next_led = ((next_state == T_HDR) || (next_state == T_MARK)) && next_car_ph; // [R5] [R13]
    end

    // State registers.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state     <= T_IDLE;
            seg       <= '0;
            frame_cnt <= '0;
            bit_idx   <= '0;
            sr        <= '0;
            car_cnt   <= '0;
            car_ph    <= 1'b0;
            led_o     <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            state     <= next_state;
            seg       <= next_seg;
            frame_cnt <= next_frame_cnt;
            bit_idx   <= next_bit_idx;
            sr        <= next_sr;
            car_cnt   <= next_car_cnt;
            car_ph    <= next_car_ph;
            led_o     <= next_led;
            busy_o    <= next_busy;
        end
    end

endmodule // irc_tx
